//--- core/acr_pkg.sv
// Function
// - Phase delay is ten-bit signed field at bits 15:6, reset zero.
// - Setup word bits 5:3 always read zero; writes cannot change them.
// - Bit 2 set disables the DC filter for that channel, else global setting.
// - Bits 1:0 select input: pins, shorted, positive test, negative test.
// - Offset bits 23:8 fill all of offset high register, reset zero.
// - Offset bits 7:0 sit in offset low 15:8; low byte reads zero.
// - Gain is unsigned 24 bits; bits 23:8 fill the gain high register.
// - Gain bits 7:0 sit in gain low 15:8; low byte resets and reads zero.
// - Gain high resets to 8000h; offset and gain low words reset to zero.
// - Channel three offset and gain words sit at 19h through 1Ch.
// - Channel four setup word at 1Dh, reset zero, same fields as channel three.
package acr_pkg;
	// ------------------------------------------------------------------
	// Register indices; byte address is four times the index
	// ------------------------------------------------------------------
	localparam logic [7:0] IDX_CHAN3_SETUP       = 8'h18;
	localparam logic [7:0] IDX_CHAN3_OFFSET_HIGH = 8'h19;
	localparam logic [7:0] IDX_CHAN3_OFFSET_LOW  = 8'h1A;
	localparam logic [7:0] IDX_CHAN3_GAIN_HIGH   = 8'h1B;
	localparam logic [7:0] IDX_CHAN3_GAIN_LOW    = 8'h1C;
	localparam logic [7:0] IDX_CHAN4_SETUP       = 8'h1D;
	localparam int         ADDR_LSB              = 2;
	localparam int         IDX_W                 = 8;

	// ------------------------------------------------------------------
	// Field layout
	// ------------------------------------------------------------------
	localparam int PHASE_MSB  = 15;
	localparam int PHASE_LSB  = 6;
	localparam int DCOFF_BIT  = 2;
	localparam int INSEL_MSB  = 1;
	localparam int INSEL_LSB  = 0;
	localparam int LOWB_MSB   = 15;
	localparam int LOWB_LSB   = 8;
	localparam logic [15:0] SETUP_MASK = 16'hFFC7;
	localparam logic [15:0] LOW_MASK   = 16'hFF00;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [15:0] RST_SETUP     = 16'h0000;
	localparam logic [15:0] RST_OFF_HIGH  = 16'h0000;
	localparam logic [15:0] RST_OFF_LOW   = 16'h0000;
	localparam logic [15:0] RST_GAIN_HIGH = 16'h8000;
	localparam logic [15:0] RST_GAIN_LOW  = 16'h0000;

	// ------------------------------------------------------------------
	// Input select codes and AHB encodings
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		ACR_IN_PINS    = 2'b00,
		ACR_IN_SHORTED = 2'b01,
		ACR_IN_TEST_P  = 2'b10,
		ACR_IN_TEST_N  = 2'b11
	} acr_insel_t;

	localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;
	localparam logic [1:0]  HTRANS_SEQ    = 2'b11;
	localparam logic        HRESP_OKAY    = 1'b0;
	localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;
endpackage

//--- core/acr_regs.sv
`timescale 1ns/100ps
module acr_regs
	import acr_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        rstn_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	output logic      [9:0]  chan3_phase_delay_o,
	output logic             chan3_dc_filter_off_o,
	output acr_insel_t       chan3_input_select_o,
	output logic      [23:0] chan3_offset_o,
	output logic      [23:0] chan3_gain_o,
	output logic      [9:0]  chan4_phase_delay_o,
	output logic             chan4_dc_filter_off_o,
	output acr_insel_t       chan4_input_select_o
);
	// ------------------------------------------------------------------
	// Storage; every register has its next value beside it
	// ------------------------------------------------------------------
	logic             wr_pend_reg;
	logic             wr_pend_next;
	logic [IDX_W-1:0] wr_idx_reg;
	logic [IDX_W-1:0] wr_idx_next;
	logic [31:0]      rdata_reg;
	logic [31:0]      rdata_next;
	logic [15:0]      chan3_setup_reg;
	logic [15:0]      chan3_setup_next;
	logic [15:0]      chan3_offset_high_reg;
	logic [15:0]      chan3_offset_high_next;
	logic [15:0]      chan3_offset_low_reg;
	logic [15:0]      chan3_offset_low_next;
	logic [15:0]      chan3_gain_high_reg;
	logic [15:0]      chan3_gain_high_next;
	logic [15:0]      chan3_gain_low_reg;
	logic [15:0]      chan3_gain_low_next;
	logic [15:0]      chan4_setup_reg;
	logic [15:0]      chan4_setup_next;

	// ------------------------------------------------------------------
	// Decode and field helpers
	// ------------------------------------------------------------------
	// Word index from the byte address; upper address bits are checked apart
	function automatic logic [IDX_W-1:0] word_idx(input logic [31:0] a);
		return a[ADDR_LSB +: IDX_W];
	endfunction

	// A write lands one cycle after its address phase, in the data phase
	function automatic logic write_hits(
		input logic             pend,
		input logic [IDX_W-1:0] idx,
		input logic [IDX_W-1:0] target
	);
		return pend & (idx == target);
	endfunction

	// Reserved setup bits are dropped on entry, so they can only read zero
	function automatic logic [15:0] setup_keep(input logic [15:0] w);
		return w & SETUP_MASK;
	endfunction

	// The low calibration words keep only their upper byte
	function automatic logic [15:0] low_keep(input logic [15:0] w);
		return w & LOW_MASK;
	endfunction

	// Field extraction, shared by both channels
	function automatic logic [9:0] phase_of(input logic [15:0] s);
		return s[PHASE_MSB:PHASE_LSB];
	endfunction

	function automatic logic filter_off_of(input logic [15:0] s);
		return s[DCOFF_BIT];
	endfunction

	function automatic acr_insel_t select_of(input logic [15:0] s);
		return acr_insel_t'(s[INSEL_MSB:INSEL_LSB]);
	endfunction

	// High word supplies bits 23:8, the low word's upper byte bits 7:0
	function automatic logic [23:0] join24(
		input logic [15:0] hi,
		input logic [15:0] lo
	);
		return {hi, lo[LOWB_MSB:LOWB_LSB]};
	endfunction

	// ------------------------------------------------------------------
	// Address phase decode
	// ------------------------------------------------------------------
	wire              addr_phase = hsel_i & hready_i & htrans_i[1];
	wire              rd_start   = addr_phase & ~hwrite_i;
	wire              wr_start   = addr_phase & hwrite_i;
	wire [IDX_W-1:0]  a_idx      = word_idx(haddr_i);
	wire              hi_clear   = (haddr_i[31:ADDR_LSB+IDX_W] == '0);

	// ------------------------------------------------------------------
	// Write decode; each strobe is live during one data phase only
	// ------------------------------------------------------------------
	// Only the low half of the write word carries data
	wire [15:0] wdat    = hwdata_i[15:0];
	wire        we_c3s  = write_hits(wr_pend_reg, wr_idx_reg, IDX_CHAN3_SETUP);
	wire        we_c3oh = write_hits(wr_pend_reg, wr_idx_reg, IDX_CHAN3_OFFSET_HIGH);
	wire        we_c3ol = write_hits(wr_pend_reg, wr_idx_reg, IDX_CHAN3_OFFSET_LOW);
	wire        we_c3gh = write_hits(wr_pend_reg, wr_idx_reg, IDX_CHAN3_GAIN_HIGH);
	wire        we_c3gl = write_hits(wr_pend_reg, wr_idx_reg, IDX_CHAN3_GAIN_LOW);
	wire        we_c4s  = write_hits(wr_pend_reg, wr_idx_reg, IDX_CHAN4_SETUP);

	// ------------------------------------------------------------------
	// Read mux; unmapped words read zero with OKAY
	// ------------------------------------------------------------------
	// A read taken in a write's data phase still sees the old word
	logic [15:0] rd_mux;
	always_comb
	begin
		rd_mux = 16'h0000;
		if (hi_clear)
		begin
			unique case (a_idx)
				IDX_CHAN3_SETUP:       rd_mux = chan3_setup_reg;
				IDX_CHAN3_OFFSET_HIGH: rd_mux = chan3_offset_high_reg;
				IDX_CHAN3_OFFSET_LOW:  rd_mux = chan3_offset_low_reg;
				IDX_CHAN3_GAIN_HIGH:   rd_mux = chan3_gain_high_reg;
				IDX_CHAN3_GAIN_LOW:    rd_mux = chan3_gain_low_reg;
				IDX_CHAN4_SETUP:       rd_mux = chan4_setup_reg;
				default:               rd_mux = 16'h0000;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Next values
	// ------------------------------------------------------------------
	// Out-of-range write is never marked pending, so it cannot alias a register
	assign wr_pend_next           = wr_start & hi_clear;
	assign wr_idx_next            = wr_start ? a_idx : wr_idx_reg;
	assign rdata_next             = rd_start ? {16'h0000, rd_mux} : rdata_reg;
	assign chan3_setup_next       = we_c3s ? setup_keep(wdat) : chan3_setup_reg;
	assign chan3_offset_high_next = we_c3oh ? wdat : chan3_offset_high_reg;
	assign chan3_offset_low_next  = we_c3ol ? low_keep(wdat) : chan3_offset_low_reg;
	assign chan3_gain_high_next   = we_c3gh ? wdat : chan3_gain_high_reg;
	assign chan3_gain_low_next    = we_c3gl ? low_keep(wdat) : chan3_gain_low_reg;
	assign chan4_setup_next       = we_c4s ? setup_keep(wdat) : chan4_setup_reg;

	// ------------------------------------------------------------------
	// Bus state
	// ------------------------------------------------------------------
	// hsize is not decoded: every access is taken as a whole word
	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
		begin
			wr_pend_reg <= 1'b0;
		end
		else
		begin
			wr_pend_reg <= wr_pend_next;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
		begin
			wr_idx_reg <= '0;
		end
		else
		begin
			wr_idx_reg <= wr_idx_next;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
		begin
			rdata_reg <= RDATA_ZERO;
		end
		else
		begin
			rdata_reg <= rdata_next;
		end
	end

	// ------------------------------------------------------------------
	// Register bank; reset values come from the package
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
		begin
			chan3_setup_reg <= RST_SETUP;
		end
		else
		begin
			chan3_setup_reg <= chan3_setup_next;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
		begin
			chan3_offset_high_reg <= RST_OFF_HIGH;
		end
		else
		begin
			chan3_offset_high_reg <= chan3_offset_high_next;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
		begin
			chan3_offset_low_reg <= RST_OFF_LOW;
		end
		else
		begin
			chan3_offset_low_reg <= chan3_offset_low_next;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
		begin
			chan3_gain_high_reg <= RST_GAIN_HIGH;
		end
		else
		begin
			chan3_gain_high_reg <= chan3_gain_high_next;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
		begin
			chan3_gain_low_reg <= RST_GAIN_LOW;
		end
		else
		begin
			chan3_gain_low_reg <= chan3_gain_low_next;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
		begin
			chan4_setup_reg <= RST_SETUP;
		end
		else
		begin
			chan4_setup_reg <= chan4_setup_next;
		end
	end

	// ------------------------------------------------------------------
	// Bus response
	// ------------------------------------------------------------------
	// Zero wait states: every transfer finishes in its first data phase
	assign hreadyout_o = 1'b1;
	assign hresp_o     = HRESP_OKAY;
	// Upper half of the read word is always zero
	assign hrdata_o    = rdata_reg;

	// ------------------------------------------------------------------
	// Channel three controls and calibration
	// ------------------------------------------------------------------
	// Halves of a 24-bit value change on separate writes; no atomic update
	assign chan3_phase_delay_o   = phase_of(chan3_setup_reg);
	assign chan3_dc_filter_off_o = filter_off_of(chan3_setup_reg);
	assign chan3_input_select_o  = select_of(chan3_setup_reg);
	assign chan3_offset_o        = join24(chan3_offset_high_reg, chan3_offset_low_reg);
	assign chan3_gain_o          = join24(chan3_gain_high_reg, chan3_gain_low_reg);

	// ------------------------------------------------------------------
	// Channel four controls
	// ------------------------------------------------------------------
	assign chan4_phase_delay_o   = phase_of(chan4_setup_reg);
	assign chan4_dc_filter_off_o = filter_off_of(chan4_setup_reg);
	assign chan4_input_select_o  = select_of(chan4_setup_reg);
endmodule // acr_regs

//--- bench/acr_regs_asserts.sv
`timescale 1ns/100ps
module acr_regs_asserts
	import acr_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        rstn_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	input  wire logic [31:0] hrdata_o,
	input  wire logic        chan3_dc_filter_off_o,
	input  wire acr_insel_t  chan3_input_select_o,
	input  wire logic [23:0] chan3_offset_o,
	input  wire logic [23:0] chan3_gain_o,
	input  wire logic [9:0]  chan4_phase_delay_o
);
	logic        tk, wr_q, rd_q;
	logic [31:0] a_q;
	logic [7:0]  ix;
	assign tk = hsel_i & hready_i & htrans_i[1];
	assign ix = a_q[9:2];
	// Data phase flags; a clock edge with reset low clears them so no stale phase survives
	always_ff @(posedge sys_clk_i)
	begin
		wr_q <= rstn_i & tk & hwrite_i;
		rd_q <= rstn_i & tk & ~hwrite_i;
		a_q  <= tk ? haddr_i : a_q;
	end
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);
	chk_gain_reset: assert property ($rose(rstn_i) |-> chan3_gain_o == 24'h80_0000)
		else $error("gain reset value wrong");
	chk_setup_reset: assert property ($rose(rstn_i) |-> !chan3_dc_filter_off_o
		&& chan3_input_select_o == 2'b00 && chan4_phase_delay_o == 10'h000) else $error("setup reset");
	chk_offset_reset: assert property ($rose(rstn_i) |-> chan3_offset_o == 24'h00_0000)
		else $error("offset reset value wrong");
	chk_gain_write: assert property (wr_q && ix == 8'h1B && a_q[31:10] == 22'h0
		|=> chan3_gain_o[23:8] == $past(hwdata_i[15:0])) else $error("gain high write lost");
	chk_offlow_write: assert property (wr_q && ix == 8'h1A && a_q[31:10] == 22'h0
		|=> chan3_offset_o[7:0] == $past(hwdata_i[15:8])) else $error("offset low write lost");
	chk_phase_write: assert property (wr_q && ix == 8'h1D && a_q[31:10] == 22'h0
		|=> chan4_phase_delay_o == $past(hwdata_i[15:6])) else $error("phase write lost");
	chk_select_write: assert property (wr_q && ix == 8'h18 && a_q[31:10] == 22'h0
		|=> {chan3_dc_filter_off_o, chan3_input_select_o} == $past(hwdata_i[2:0]))
		else $error("select write lost");
	chk_unmapped_read: assert property (rd_q && (a_q[31:10] != 22'h0 || ix < 8'h18
		|| ix > 8'h1D) |-> hrdata_o == 32'h0) else $error("unmapped read not zero");
	chk_reserved_read: assert property (rd_q && ix == 8'h1C |-> hrdata_o[7:0] == 8'h00)
		else $error("reserved gain bits not zero");
endmodule // acr_regs_asserts

bind acr_regs acr_regs_asserts u_chk (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i),
	.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
	.hready_i(hready_i), .hrdata_o(hrdata_o), .chan3_dc_filter_off_o(chan3_dc_filter_off_o),
	.chan3_input_select_o(chan3_input_select_o), .chan3_offset_o(chan3_offset_o),
	.chan3_gain_o(chan3_gain_o), .chan4_phase_delay_o(chan4_phase_delay_o));

//--- bench/acr_regs_bench.sv
`timescale 1ns/100ps
module acr_regs_bench
	import acr_pkg::*;
;
	logic        sys_clk_i, rstn_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, c3_dc, c4_dc;
	logic [1:0]  htrans_i;
	logic [31:0] haddr_i, hwdata_i, hrdata_o, r;
	logic [9:0]  c3_ph, c4_ph;
	logic [23:0] c3_off, c3_gain;
	acr_insel_t  c3_sel, c4_sel;
	logic [15:0] d;
	int          errors, n_compared, i, k;
	logic [31:0] ad [6] = '{32'h60, 32'h64, 32'h68, 32'h6C, 32'h70, 32'h74};
	logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h0, 32'h8000, 32'h0, 32'h0};
	logic [31:0] mk [6] = '{32'hFFC7, 32'hFFFF, 32'hFF00, 32'hFFFF, 32'hFF00, 32'hFFC7};
	acr_regs dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'b010), .hwdata_i(hwdata_i),
		.hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
		.chan3_phase_delay_o(c3_ph), .chan3_dc_filter_off_o(c3_dc), .chan3_input_select_o(c3_sel),
		.chan3_offset_o(c3_off), .chan3_gain_o(c3_gain), .chan4_phase_delay_o(c4_ph),
		.chan4_dc_filter_off_o(c4_dc), .chan4_input_select_o(c4_sel));
	// ------------------------------------------------------------------
	// Bus tasks; each is entered just after a rising edge
	// ------------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
		htrans_i <= HTRANS_NONSEQ;
		hwrite_i <= w;
		haddr_i  <= a;
		do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
		htrans_i <= 2'b00;
		hwdata_i <= wd;
		do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
		r = hrdata_o;
		check({31'h0, hresp_o}, 32'h0);
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		check(r, exp);
	endtask
	task automatic tally_and_finish;
		$display("errors %0d n_compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		sys_clk_i = 1'b0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end
	initial
	begin
		repeat (5000) @(posedge sys_clk_i);
		errors++;
		tally_and_finish();
	end
	initial
	begin
		{rstn_i, htrans_i, hwrite_i, haddr_i, hwdata_i, errors, n_compared} = '0;
		hsel_i = 1'b1;
		repeat (8) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		for (i = 0; i < 6; i++)
			rd(ad[i], rv[i]);
		for (i = 0; i < 6; i++)
		begin
			xfer(1'b1, ad[i], 32'hFFFF_FFFF);
			rd(ad[i], mk[i]);
		end
		// Every input select code with reserved bits set, both channels
		for (k = 0; k < 2; k++)
			for (i = 0; i < 4; i++)
			begin
				d = {10'h200 + 10'(i), 3'b111, i[0], i[1:0]};
				xfer(1'b1, k ? 32'h74 : 32'h60, {16'hFFFF, d});
				rd(k ? 32'h74 : 32'h60, {16'h0, d & 16'hFFC7});
				check(k ? {16'h0, c4_ph, 3'b000, c4_dc, c4_sel} : {16'h0, c3_ph, 3'b000, c3_dc, c3_sel},
					{16'h0, d & 16'hFFC7});
			end
		xfer(1'b1, 32'h64, 32'hFFFF_8123);
		xfer(1'b1, 32'h68, 32'h0000_AB55);
		xfer(1'b1, 32'h6C, 32'h0000_4567);
		xfer(1'b1, 32'h70, 32'h0000_CD99);
		rd(32'h70, 32'h0000_CD00);
		check({8'h00, c3_off}, 32'h0081_23AB);
		check({8'h00, c3_gain}, 32'h0045_67CD);
		// Unmapped index and an alias with high address bits set
		xfer(1'b1, 32'h78, 32'h0000_FFFF);
		xfer(1'b1, 32'h464, 32'h0000_0000);
		rd(32'h78, 32'h0);
		rd(32'h464, 32'h0);
		rd(32'h64, 32'h0000_8123);
		rstn_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		rd(32'h6C, 32'h0000_8000);
		check({8'h00, c3_gain}, 32'h0080_0000);
		tally_and_finish();
	end
endmodule // acr_regs_bench
